/* include/mds_params.svh */
// Purpose: Constants for the multichannel DMA sequencer
// Assumes: 24-bit words and addresses, six channels
// Notes:   Counter field masks fix the split of the 24-bit counter
`ifndef MDS_PARAMS_SVH
`define MDS_PARAMS_SVH

`define MDS_NCH        6
`define MDS_AW         24
`define MDS_DW         24
`define MDS_CW         24
`define MDS_NTRIG      16
`define MDS_TSW        4
`define MDS_FIFO_DEPTH 8
`define MDS_CNT_RST    24'h000000
`define MDS_ADDR_RST   24'h000000
`define MDS_LO2_MSK    24'h000fff
`define MDS_LO3_MSK    24'h0000ff
`define MDS_MID3_MSK   24'h00ff00
`define MDS_FULL_MSK   24'hffffff
`define MDS_PART_SHIFT 8
`define MDS_EXT_BASE   24'h010000

`endif

/* include/mds_pkg.sv */
// Purpose: Types shared by the DMA sequencer files
// Assumes: mds_params.svh gives the widths
// Notes:   Nothing here is imported; users write mds_pkg::name
`include "mds_params.svh"

package mds_pkg;

    typedef enum logic [1:0] {
        DIM_CONST = 2'h0,
        DIM_1D    = 2'h1,
        DIM_2D    = 2'h2,
        DIM_3D    = 2'h3
    } mds_dim_e;

    typedef enum logic [1:0] {
        TM_WORD  = 2'h0,
        TM_LINE  = 2'h1,
        TM_BLOCK = 2'h2
    } mds_tmode_e;

    // Gray along idle, read, write
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_RD   = 2'h1,
        ST_WR   = 2'h3
    } mds_state_e;

    typedef struct packed {
        logic                en;
        logic                hw_trig;
        mds_tmode_e          tmode;
        logic                repeat_blk;
        logic [`MDS_TSW-1:0] tsel;
        mds_dim_e            sdim;
        mds_dim_e            ddim;
        logic [1:0]          so1;
        logic [1:0]          so2;
        logic [1:0]          do1;
        logic [1:0]          do2;
        logic [`MDS_CW-1:0]  cnt_init;
    } mds_cfg_s;

    typedef struct packed {
        logic               valid;
        logic [2:0]         ch;
        logic [`MDS_AW-1:0] src;
        logic [`MDS_AW-1:0] dst;
    } mds_load_s;

    typedef struct packed {
        logic [`MDS_CW-1:0] cnt;
        logic [1:0]         wrap;
    } mds_step_s;

endpackage : mds_pkg

/* rtl/mds_fifo.sv */
// Purpose: Word FIFO between the DMA read and write phases
// Assumes: One clock; ce low freezes everything
// Notes:   Head word sits in a register; capacity is D plus one
`timescale 1ns/10ps

module mds_fifo #(
    parameter int W = 24,
    parameter int D = 8
) (
    // Clock, reset, freeze
    input  wire logic         clock,
    input  wire logic         sys_rst,
    input  wire logic         ce,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int PW = $clog2(D);
    localparam int CNW = $clog2(D + 1);

    logic [W-1:0]   mem [D];
    logic [PW-1:0]  wp_r;
    logic [PW-1:0]  rp_r;
    logic [CNW-1:0] cnt_r;
    logic           push;
    logic           ld_out;
    logic           byp;
    logic           from_mem;

    // Handshakes; full only when the array is full
    assign in_ready = (cnt_r != CNW'(D));
    assign push     = in_valid & in_ready;
    assign ld_out   = ~out_valid | out_ready;
    assign from_mem = ld_out & (cnt_r != '0);
    assign byp      = ld_out & (cnt_r == '0) & push;

    // Array write and pointers
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end
        else if (ce)
        begin
            if (push & ~byp)
            begin
                mem[wp_r] <= in_data;
                wp_r      <= PW'((wp_r + 1'b1) % D);
            end
            if (from_mem)
                rp_r <= PW'((rp_r + 1'b1) % D);
            cnt_r <= cnt_r + CNW'(push & ~byp) - CNW'(from_mem);
        end
    end

    // Head register; empty array lets a push go straight through
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end
        else if (ce & ld_out)
        begin
            out_valid <= from_mem | byp;
            if (from_mem)
                out_data <= mem[rp_r];
            else if (byp)
                out_data <= in_data;
        end
    end

endmodule : mds_fifo

/* rtl/mds_dma_seq.sv */
// Purpose: Six-channel DMA sequencer: triggers, counters, word moves
// Assumes: One core clock; bus_wait stretches an access; ce freezes all
// Notes:   Fixed priority, lowest channel first; one word in flight
`timescale 1ns/10ps
`include "mds_params.svh"

// Notes on behaviour
// [R1] Each side addresses constant, line, two-dimensional or three-dimensional data.
// [R2] Counter mode splits the 24-bit counter into one field per dimension.
// [R3] Each word decrements a field; a zero field reloads its programmed value.
// [R4] All fields exhausted means the block is complete.
// [R5] Counting acts on the visible counter itself, no hidden copy.
// [R6] The higher-dimension side chooses the counter mode.
// [R7] One count step is one source read then one destination write.
// [R8] Lower-dimension side uses only low fields, repeating its address sequence.
// [R9] A channel listens to exactly one selected trigger source.
// [R10] Triggers: interrupt pins, block completions, peripheral status bits.
// [R11] Peripheral status change starts the move, interrupt enable irrelevant.
// [R12] Software should not use one event for both trigger and interrupt.
// [R13] A triggered enabled channel starts once bus and memory are free.
// [R14] Transfer mode sets word, line or block per trigger, trigger kind, repeat.
// [R15] A free word move takes at least two cycles: read then write.
// [R16] External wait states lengthen the word by the same cycles.
// [R17] Requests every two cycles are served back to back without gaps.
// [R18] Only one channel moves data per cycle, holding the bus through waits.
// [R19] Another triggered channel may start the cycle after a word ends.
// [R20] Core and DMA run together on different partitions or memories.
// [R21] Core wins a shared internal partition; the DMA access waits.
// [R22] After reset every channel is idle and disarmed.
module mds_dma_seq (
    // Clock, reset and freeze
    input  wire logic                                 clock,
    input  wire logic                                 sys_rst,
    input  wire logic                                 ce,
    // Channel configuration, address loads and shared offsets
    input  wire mds_pkg::mds_cfg_s [`MDS_NCH-1:0]     cfg,
    input  wire mds_pkg::mds_load_s                   ld,
    input  wire logic [3:0][`MDS_AW-1:0]              dor,
    // Trigger sources
    input  wire logic [3:0]                           irq,
    input  wire logic [`MDS_NCH-1:0]                  periph,
    // Core access, for partition contention
    input  wire logic                                 core_req,
    input  wire logic [`MDS_AW-1:0]                   core_addr,
    // DMA memory bus
    output logic                                      bus_rd,
    output logic                                      bus_wr,
    output logic [`MDS_AW-1:0]                        bus_addr,
    output logic [`MDS_DW-1:0]                        bus_wdata,
    input  wire logic [`MDS_DW-1:0]                   bus_rdata,
    input  wire logic                                 bus_wait,
    // Channel status
    output logic [`MDS_NCH-1:0][`MDS_CW-1:0]          cnt_q,
    output logic [`MDS_NCH-1:0][`MDS_AW-1:0]          src_q,
    output logic [`MDS_NCH-1:0][`MDS_AW-1:0]          dst_q,
    output logic [`MDS_NCH-1:0]                       armed,
    output logic [`MDS_NCH-1:0]                       blk_done,
    output logic                                      busy,
    output logic [2:0]                                owner
);
    logic [`MDS_NCH-1:0][`MDS_CW-1:0] cnt_r;
    logic [`MDS_NCH-1:0][`MDS_AW-1:0] src_r;
    logic [`MDS_NCH-1:0][`MDS_AW-1:0] dst_r;
    logic [`MDS_NCH-1:0]              arm_r;
    logic [`MDS_NCH-1:0]              pend_r;
    logic [`MDS_NCH-1:0]              run_r;
    logic [`MDS_NCH-1:0]              tprev_r;
    logic [`MDS_NCH-1:0]              enprev_r;
    logic [`MDS_NCH-1:0]              blk_r;
    mds_pkg::mds_state_e              st_r;
    logic [2:0]                       cur_r;
    mds_pkg::mds_cfg_s                cc;
    mds_pkg::mds_dim_e                mode;
    mds_pkg::mds_step_s               stp;
    logic [`MDS_NTRIG-1:0]            trig;
    logic [`MDS_NCH-1:0]              ready;
    logic [`MDS_NCH-1:0]              ready_nx;
    logic [`MDS_CW-1:0]               cnt_cur;
    logic                             conflict;
    logic                             rd_done;
    logic                             wr_done;
    logic                             line_end;
    logic                             blk_end;
    logic                             run_end;
    logic                             sw_again;
    logic                             keep_cur;
    logic                             start;
    logic [2:0]                       start_ch;
    logic                             f_in_ready;
    logic                             f_out_valid;

    // Lowest ready channel wins; channel number is the only priority
    function automatic logic [2:0] pick(input logic [`MDS_NCH-1:0] r);
        logic [2:0] k;
        k = 3'h0;
        for (int i = `MDS_NCH - 1; i >= 0; i--)
            if (r[i])
                k = 3'(i);
        return k;
    endfunction : pick

    function automatic logic is_ext(input logic [`MDS_AW-1:0] a);
        return a >= `MDS_EXT_BASE;
    endfunction : is_ext

    // Same internal quarter-kiloword partition
    function automatic logic part_hit(input logic [`MDS_AW-1:0] a,
                                      input logic [`MDS_AW-1:0] b);
        return ~is_ext(a) & ~is_ext(b) &
               ((a >> `MDS_PART_SHIFT) == (b >> `MDS_PART_SHIFT)); // [R20]
    endfunction : part_hit

    // Counter step: returns the new count and how far the carry reached
    function automatic mds_pkg::mds_step_s cnt_step(input logic [`MDS_CW-1:0] c,
                                                    input logic [`MDS_CW-1:0] ini,
                                                    input mds_pkg::mds_dim_e m);
        logic [`MDS_CW-1:0] ml;
        logic [`MDS_CW-1:0] mm;
        logic [`MDS_CW-1:0] mh;
        logic [`MDS_CW-1:0] um;
        logic [`MDS_CW-1:0] uh;
        mds_pkg::mds_step_s s;
        ml = (m == mds_pkg::DIM_3D) ? `MDS_LO3_MSK :
             (m == mds_pkg::DIM_2D) ? `MDS_LO2_MSK : `MDS_FULL_MSK; // [R2]
        mm = (m == mds_pkg::DIM_3D) ? `MDS_MID3_MSK : `MDS_CNT_RST;
        mh = (m >= mds_pkg::DIM_2D) ? ~(ml | mm) : `MDS_CNT_RST;
        um = mm & (~mm + 24'h000001);
        uh = mh & (~mh + 24'h000001);
        if ((c & ml) != `MDS_CNT_RST)
            s = '{cnt: c - 24'h000001, wrap: 2'h0}; // [R3]
        else if ((c & mm) != `MDS_CNT_RST)
            s = '{cnt: ((c - um) & ~ml) | (ini & ml), wrap: 2'h1}; // [R3]
        else if ((c & mh) != `MDS_CNT_RST)
            s = '{cnt: ((c - uh) & mh) | (ini & ~mh), wrap: 2'h2}; // [R3]
        else
            s = '{cnt: ini, wrap: 2'h3}; // [R4]
        return s;
    endfunction : cnt_step

    // Address step; a lower-dimension side wraps back by its offsets
    function automatic logic [`MDS_AW-1:0] addr_next(input logic [`MDS_AW-1:0] a,
                                                     input mds_pkg::mds_dim_e d,
                                                     input logic [1:0] o1,
                                                     input logic [1:0] o2,
                                                     input logic [1:0] w);
        if (d == mds_pkg::DIM_CONST)
            return a; // [R1]
        else if (w == 2'h0)
            return a + 24'h000001; // [R1]
        else if (w == 2'h1)
            return a + dor[o1]; // [R8]
        else
            return a + dor[o2]; // [R8]
    endfunction : addr_next

    // Current channel view and counter step
    assign cc      = cfg[cur_r];
    assign mode    = (cc.sdim > cc.ddim) ? cc.sdim : cc.ddim; // [R6]
    assign cnt_cur = cnt_r[cur_r];
    assign stp     = cnt_step(cnt_cur, cc.cnt_init, mode); // [R5]
    assign line_end = (stp.wrap != 2'h0);
    assign blk_end  = (stp.wrap == 2'h3); // [R4]

    // Trigger sources: pins, block completions, peripheral status
    assign trig = {periph, blk_r, irq}; // [R10]

    // Bus drive; core keeps a shared partition, DMA waits
    assign bus_addr = (st_r == mds_pkg::ST_WR) ? dst_r[cur_r] : src_r[cur_r];
    assign conflict = core_req & part_hit(core_addr, bus_addr); // [R21]
    assign bus_rd   = (st_r == mds_pkg::ST_RD) & ~conflict & f_in_ready; // [R13]
    assign bus_wr   = (st_r == mds_pkg::ST_WR) & ~conflict & f_out_valid; // [R18]
    assign rd_done  = bus_rd & ~bus_wait; // [R16]
    assign wr_done  = bus_wr & ~bus_wait; // [R16]

    // Amount per trigger and what keeps the current channel going
    always_comb
    begin
        case (cc.tmode)
            mds_pkg::TM_WORD:  run_end = 1'b1; // [R14]
            mds_pkg::TM_LINE:  run_end = line_end; // [R14]
            mds_pkg::TM_BLOCK: run_end = blk_end; // [R14]
            default:           run_end = 1'b1;
        endcase
        sw_again = blk_end & cc.repeat_blk & ~cc.hw_trig; // [R14]
        keep_cur = ~(blk_end & ~cc.repeat_blk) &
                   (pend_r[cur_r] | ~run_end | sw_again);
    end

    // Ready channels; ready_nx sees the current one after this word
    always_comb
    begin
        for (int i = 0; i < `MDS_NCH; i++)
            ready[i] = arm_r[i] & cfg[i].en & (pend_r[i] | run_r[i]);
        ready_nx = ready;
        ready_nx[cur_r] = keep_cur & cc.en;
    end

    // Start of a word: from idle, or straight after a write
    assign start    = ((st_r == mds_pkg::ST_IDLE) & (|ready)) |
                      (wr_done & (|ready_nx)); // [R19]
    assign start_ch = (st_r == mds_pkg::ST_IDLE) ? pick(ready) : pick(ready_nx);

    // Word sequencer: read, then write, then next word at once
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            st_r  <= mds_pkg::ST_IDLE; // [R22]
            cur_r <= 3'h0;
        end
        else if (ce)
        begin
            if (start)
                cur_r <= start_ch; // [R18]
            case (st_r)
                mds_pkg::ST_IDLE:
                    if (start)
                        st_r <= mds_pkg::ST_RD; // [R13]
                mds_pkg::ST_RD:
                    if (rd_done)
                        st_r <= mds_pkg::ST_WR; // [R7]
                mds_pkg::ST_WR: // [R15]
                    if (wr_done)
                        st_r <= start ? mds_pkg::ST_RD : mds_pkg::ST_IDLE; // [R17]
                default:
                    st_r <= mds_pkg::ST_IDLE;
            endcase
        end
    end

    // Arming follows the enable; a block without repeat disarms
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            arm_r    <= '0; // [R22]
            enprev_r <= '0;
        end
        else if (ce)
        begin
            for (int i = 0; i < `MDS_NCH; i++)
            begin
                enprev_r[i] <= cfg[i].en;
                if (~cfg[i].en)
                    arm_r[i] <= 1'b0;
                else if (~enprev_r[i])
                    arm_r[i] <= 1'b1;
                else if (wr_done & (cur_r == 3'(i)) & blk_end & ~cc.repeat_blk)
                    arm_r[i] <= 1'b0; // [R4]
            end
        end
    end

    // Pending triggers; a new trigger beats the clear of the same cycle
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            pend_r  <= '0; // [R22]
            tprev_r <= '0;
        end
        else if (ce)
        begin
            for (int i = 0; i < `MDS_NCH; i++)
            begin
                tprev_r[i] <= trig[cfg[i].tsel]; // [R9]
                if (~cfg[i].en)
                    pend_r[i] <= 1'b0;
                else if (cfg[i].hw_trig ? (trig[cfg[i].tsel] & ~tprev_r[i]) // [R11]
                                        : ~enprev_r[i])
                    pend_r[i] <= 1'b1; // [R9]
                else if (wr_done & (cur_r == 3'(i)) & sw_again)
                    pend_r[i] <= 1'b1; // [R14]
                else if (start & (start_ch == 3'(i)))
                    pend_r[i] <= 1'b0;
            end
        end
    end

    // Line and block modes keep a channel running past one word
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            run_r <= '0; // [R22]
        else if (ce)
        begin
            for (int i = 0; i < `MDS_NCH; i++)
                if (~cfg[i].en)
                    run_r[i] <= 1'b0;
            if (wr_done & run_end)
                run_r[cur_r] <= 1'b0;
            if (start & (cfg[start_ch].tmode != mds_pkg::TM_WORD))
                run_r[start_ch] <= 1'b1; // [R14]
        end
    end

    // Counters and pointers, updated in place after each write
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            cnt_r <= '0;
            src_r <= '0;
            dst_r <= '0;
        end
        else if (ce)
        begin
            if (wr_done)
            begin
                cnt_r[cur_r] <= stp.cnt; // [R5]
                src_r[cur_r] <= addr_next(src_r[cur_r], cc.sdim, cc.so1, cc.so2,
                                          stp.wrap); // [R8]
                dst_r[cur_r] <= addr_next(dst_r[cur_r], cc.ddim, cc.do1, cc.do2,
                                          stp.wrap); // [R8]
            end
            // Software load wins over a step on the same channel
            if (ld.valid)
            begin
                cnt_r[ld.ch] <= cfg[ld.ch].cnt_init;
                src_r[ld.ch] <= ld.src;
                dst_r[ld.ch] <= ld.dst;
            end
        end
    end

    // Block completion pulse, also a trigger for any channel
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            blk_r <= '0;
        else if (ce)
        begin
            blk_r <= '0;
            if (wr_done & blk_end)
                blk_r[cur_r] <= 1'b1; // [R4]
        end
    end

    // Read data waits in the FIFO until the write phase takes it
    mds_fifo #(
        .W (`MDS_DW),
        .D (`MDS_FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .ce        (ce),
        .in_valid  (rd_done),
        .in_ready  (f_in_ready),
        .in_data   (bus_rdata),
        .out_valid (f_out_valid),
        .out_ready (wr_done),
        .out_data  (bus_wdata)
    );

    // Status views
    assign cnt_q    = cnt_r;
    assign src_q    = src_r;
    assign dst_q    = dst_r;
    assign armed    = arm_r;
    assign blk_done = blk_r;
    assign busy     = (st_r != mds_pkg::ST_IDLE);
    assign owner    = cur_r;

    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst || !ce);

    sequence s_read;
        bus_rd && !bus_wait;
    endsequence
    sequence s_write;
        bus_wr && !bus_wait;
    endsequence

    a_one_mover: assert property (!(bus_rd && bus_wr)) // [R18]
        else $error("read and write in one cycle");
    a_read_write: assert property (s_read |=> st_r == mds_pkg::ST_WR && $stable(cur_r)) // [R7]
        else $error("read not followed by write of same channel");
    a_two_cycles: assert property (s_write |-> $past(st_r) != mds_pkg::ST_IDLE) // [R15]
        else $error("write without a preceding read cycle");
    a_core_wins: assert property (core_req && part_hit(core_addr, bus_addr)
                                  |-> !bus_rd && !bus_wr) // [R21]
        else $error("DMA accessed partition held by core");
    a_wait_hold: assert property (st_r == mds_pkg::ST_RD && bus_wait
                                  |=> st_r == mds_pkg::ST_RD) // [R16]
        else $error("wait state did not stretch the read");
    a_no_gap: assert property (s_write ##0 (|ready_nx) |=> st_r == mds_pkg::ST_RD) // [R19]
        else $error("gap before next ready word");
    a_cnt_dec: assert property (s_write ##0 stp.wrap == 2'h0 && !ld.valid
                                |=> cnt_r[$past(cur_r)] == $past(cnt_cur) - 24'h000001) // [R3]
        else $error("counter did not decrement");
    a_blk_end: assert property (s_write ##0 blk_end
                                |=> blk_r[$past(cur_r)] ##1 !blk_r[$past(cur_r, 2)]) // [R4]
        else $error("block end pulse wrong");
    a_reset_idle: assert property (@(posedge clock) disable iff (1'b0)
                                   sys_rst |=> st_r == mds_pkg::ST_IDLE && arm_r == '0) // [R22]
        else $error("not idle after reset");

endmodule : mds_dma_seq

/* tb/mds_mem_model.sv */
// Purpose: Memory behind the DMA bus, with settable wait states
// Assumes: 64 words, address bits 5:0 pick a word
// Notes:   Idle read data is inverted so a stale value never matches
`timescale 1ns/10ps

module mds_mem_model (
    // Clock and wait setting
    input  wire logic        clock,
    input  wire logic [3:0]  waits,
    // DMA bus
    input  wire logic        bus_rd,
    input  wire logic        bus_wr,
    input  wire logic [23:0] bus_addr,
    input  wire logic [23:0] bus_wdata,
    output logic [23:0]      bus_rdata,
    output logic             bus_wait
);
    logic [23:0] mem [64];
    logic [3:0]  wcnt_r;
    logic [23:0] last_r;

    // Known contents: word i holds a000 plus i
    initial
    begin
        for (int i = 0; i < 64; i++)
            mem[i] = 24'h00a000 + 24'(i);
        wcnt_r = 4'h0;
        last_r = 24'h000000;
    end

    // Every access is held off by the same number of waits
    assign bus_wait  = (bus_rd | bus_wr) && (wcnt_r != waits);
    assign bus_rdata = bus_rd ? mem[bus_addr[5:0]] : ~last_r;

    // Wait count, write storage, last read value
    always @(posedge clock)
    begin
        wcnt_r <= bus_wait ? wcnt_r + 4'h1 : 4'h0;
        if (bus_rd)
            last_r <= mem[bus_addr[5:0]];
        if (bus_wr && !bus_wait)
            mem[bus_addr[5:0]] <= bus_wdata;
    end
endmodule : mds_mem_model

/* tb/testbench.sv */
// Purpose: Self-checking bench for the DMA sequencer, channel 0
// Assumes: 1D moves, offsets zero; software block mode, then pin-triggered words
// Notes:   Core access is driven to provoke partition contention
`timescale 1ns/10ps
`include "mds_params.svh"

`define CHK(a, e) \
    begin \
        checked++; \
        if ((a) !== (e)) \
        begin \
            error_cnt++; \
            $display("CHECK FAILED at %0t: value mismatch", $time); \
        end \
    end

module testbench;
    logic                                clock = 1'b0;
    logic                                sys_rst = 1'b1;
    mds_pkg::mds_cfg_s [`MDS_NCH-1:0]    cfg;
    mds_pkg::mds_load_s                  ld;
    logic                                core_req = 1'b0;
    logic [23:0]                         core_addr = 24'h000000;
    logic                                bus_rd, bus_wr, bus_wait, busy;
    logic [23:0]                         bus_addr, bus_wdata, bus_rdata;
    logic [`MDS_NCH-1:0][23:0]           cnt_q, src_q, dst_q;
    logic [2:0]                          owner;
    logic [3:0]                          irq = 4'h0;
    logic [`MDS_NCH-1:0]                 armed, blk_done;
    logic [3:0]                          waits = 4'h0;
    int                                  error_cnt = 0;
    int                                  checked = 0;

    // 100 MHz core clock
    always #5 clock = ~clock;

    mds_dma_seq u_dut (.clock(clock), .sys_rst(sys_rst), .ce(1'b1), .cfg(cfg), .ld(ld),
        .dor('0), .irq(irq), .periph('0), .core_req(core_req), .core_addr(core_addr),
        .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .bus_wait(bus_wait), .cnt_q(cnt_q), .src_q(src_q),
        .dst_q(dst_q), .armed(armed), .blk_done(blk_done), .busy(busy), .owner(owner));

    mds_mem_model u_mem (.clock(clock), .waits(waits), .bus_rd(bus_rd), .bus_wr(bus_wr),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .bus_wait(bus_wait));

    task automatic end_of_test();
        if (error_cnt == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    // One block on channel 0, started by software or pin 0 as cfg[0].hw_trig selects; strobe cycles are counted, not wall time,
    // so contention stalls do not disturb the expected figure
    task automatic run_blk(input logic [3:0] w, input logic [23:0] caddr, input int ccyc,
                           input int nw, input logic [23:0] dst);
        int strobes;
        int ovl;
        int cyc;
        strobes = 0;
        ovl = 0;
        cyc = 0;
        waits <= w;
        cfg[0].cnt_init <= 24'(nw - 1);
        @(posedge clock);
        ld <= '{valid: 1'b1, ch: 3'h0, src: 24'h000010, dst: dst};
        @(posedge clock);
        ld.valid <= 1'b0;
        cfg[0].en <= 1'b1;
        core_req <= (ccyc > 0);
        core_addr <= caddr;
        // Sampled at the edge, so each pass sees the cycle that just ended
        while (blk_done[0] !== 1'b1 && cyc < 300)
        begin
            @(posedge clock);
            cyc++;
            if (bus_rd | bus_wr)
                strobes++;
            if (core_req && (bus_rd | bus_wr))
                ovl++;
            if (cyc >= ccyc)
                core_req <= 1'b0;
            irq <= {3'h0, cyc[2]};
        end
        `CHK(blk_done[0], 1'b1)
        `CHK(strobes, nw * (2 + 2 * int'(w)))
        `CHK(cnt_q[0], 24'(nw - 1))
        `CHK(armed[0], 1'b0)
        `CHK(ovl > 0, (ccyc > 0) && (caddr[23:8] != dst[23:8]))
        `CHK(src_q[0], 24'h000010 + 24'(nw - 1))
        `CHK(dst_q[0], dst + 24'(nw - 1))
        `CHK(owner, 3'h0)
        for (int i = 0; i < nw; i++)
            `CHK(u_mem.mem[dst[5:0] + 6'(i)], 24'h00a010 + 24'(i))
        cfg[0].en <= 1'b0;
        @(posedge clock);
    endtask : run_blk

    task automatic t_reset();
        `CHK({busy, armed, bus_rd, bus_wr}, 9'h000)
    endtask : t_reset

    task automatic t_plain();
        run_blk(4'h0, 24'h000300, 0, 4, 24'h000020);
    endtask : t_plain

    task automatic t_waits();
        run_blk(4'h2, 24'h000300, 0, 3, 24'h000028);
    endtask : t_waits

    task automatic t_contend();
        run_blk(4'h0, 24'h000015, 4, 3, 24'h000030);
    endtask : t_contend

    task automatic t_overlap();
        run_blk(4'h0, 24'h000300, 4, 2, 24'h000038);
    endtask : t_overlap

    // Pin 0 rises every eight cycles; word mode moves one word per rise
    task automatic t_hwtrig();
        cfg[0].hw_trig <= 1'b1;
        cfg[0].tmode <= mds_pkg::TM_WORD;
        run_blk(4'h1, 24'h000300, 0, 3, 24'h000040);
    endtask : t_hwtrig

    // Main sequence
    initial
    begin
        cfg = '0;
        ld = '0;
        cfg[0].tmode = mds_pkg::TM_BLOCK;
        cfg[0].sdim = mds_pkg::DIM_1D;
        cfg[0].ddim = mds_pkg::DIM_1D;
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        t_reset();
        t_plain();
        t_waits();
        t_contend();
        t_overlap();
        t_hwtrig();
        end_of_test();
    end

    // Watchdog: the tests need far fewer than 10000 cycles
    initial
    begin
        #100000;
        error_cnt++;
        end_of_test();
    end
endmodule : testbench
